// ---- far_side_model.sv ----
// far-side model: trigger source with pull-up, external and shared clock pins
`timescale 1ns/100ps
module far_side_model (
   // bench commands
   input wire logic clk_sys_in,
   input wire logic drive_en_in,
   input wire logic trig_level_in,
   input wire logic edge_req_in,
   // pins toward the device
   output logic ext_trigger_out,
   output logic ext_sample_clock_out,
   output logic shared_sample_clock_out
);
   logic [2:0] hold_ff = 3'h0;
   // undriven trigger pin is pulled high
   assign ext_trigger_out = drive_en_in ? trig_level_in : 1'b1;
   // clock pins stand low outside requested edges
   always_ff @(posedge clk_sys_in)
      hold_ff <= edge_req_in ? 3'h4 : hold_ff - {2'h0, hold_ff != 3'h0};
   assign ext_sample_clock_out = hold_ff != 3'h0;
   assign shared_sample_clock_out = hold_ff != 3'h0;
endmodule

// ---- sample_group_pkg.sv ----
// constants and types shared by the sample group sequencer
package sample_group_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_INTERVAL = 8'h04;
   localparam logic [7:0] ADDR_LIST = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   // control fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_TRIG_LSB = 1;
   localparam int CTRL_WIDTH4_BIT = 3;
   localparam int CTRL_RANGE10_BIT = 4;
   localparam int CTRL_LISTCLK_BIT = 5;
   localparam int CTRL_SRC_LSB = 6;
   localparam int CTRL_MASTER_BIT = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0020;
   // sample interval in system clock cycles
   localparam logic [31:0] INTERVAL_RESET = 32'h0000_0064;
   // channel list: length minus one, then four entries of group and expansion select
   localparam int LIST_LEN_LSB = 0;
   localparam int LIST_ENTRY_LSB = 2;
   localparam int LIST_ENTRY_W = 7;
   localparam int LIST_ENTRIES = 4;
   localparam int EXP_W = 5;
   localparam logic [31:0] LIST_RESET = 32'h0000_0201;
   // status fields
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_IDX_LSB = 4;
   localparam int STAT_TRIG_BIT = 6;
   localparam int STAT_SLOW_BIT = 7;
   localparam int STAT_ACTIVE_BIT = 8;
   // least interval for the ten-volt range with several groups
   localparam int RANGE10_MIN_NS = 2400;
   localparam int RANGE10_MIN_CYC = (RANGE10_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      TRIG_OFF = 2'h0,
      TRIG_ONESHOT = 2'h1,
      TRIG_GATED = 2'h2
   } hw_trigger_mode_t;

   typedef enum logic [1:0] {
      SRC_INTERNAL = 2'h0,
      SRC_EXTERNAL = 2'h1,
      SRC_SHARED = 2'h2
   } clock_source_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ARM = 4'h2,
      ST_RUN = 4'h4,
      ST_HOLD = 4'h8
   } seq_state_t;
endpackage

// ---- sample_group_sequencer.sv ----
// sample group sequencer with trigger gating and register slave
//
// Function
// - drive five expansion-select lines addressing up to eight 64-input boards
// - external trigger is active high
// - trigger acts as one-shot start or level gate per trigger mode
// - trigger mode off means the trigger input is ignored
// - open trigger input reads as asserted
// - internal sampling clock is copied onto a dedicated output
// - one range setting applies to all eight converter sections
// - range selects five-volt or ten-volt symmetric encoding
// - master drives shared sampling clock when on the internal source, slave samples on it
// - conversion is always whole groups of eight or four channels
// - eight-wide: group zero even inputs, group one odd inputs
// - four-wide: even 0-6, odd 1-7, even 8-14, odd 9-15
// - expansion select shows next input's top bits one sample early
// - list clocking: each external clock edge starts the whole channel list
// - trigger mode is one-shot, gated or off, off after reset
`timescale 1ns/100ps
module sample_group_sequencer #(
   parameter int INTERVAL_W = 32
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic srst_in,
   // register bus
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   output logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   input wire logic [7:0] s_axi_araddr_in,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   // external pins
   input wire logic ext_trigger_in,
   input wire logic ext_sample_clock_in,
   input wire logic shared_sample_clock_in,
   output logic internal_sample_clock_out,
   output logic shared_sample_clock_out,
   output logic [4:0] expansion_select_out,
   // converter side
   output logic conv_start_out,
   output logic [15:0] pin_select_out,
   output logic [7:0] conv_enable_out,
   output logic mux_odd_out,
   output logic [1:0] group_out,
   output logic range_10v_out
);
   if (INTERVAL_W < 8 || INTERVAL_W > 32)
   begin : g_check
      $error("INTERVAL_W must lie between 8 and 32");
   end

   logic [31:0] ctrl_ff;
   logic [31:0] interval_ff;
   logic [31:0] list_ff;
   logic [2:0] pin_meta_ff;
   logic [2:0] pin_sync_ff;
   logic [2:0] pin_prev_ff;
   sample_group_pkg::seq_state_t state_ff;
   sample_group_pkg::seq_state_t nxt_state;
   logic [1:0] idx_ff;
   logic [1:0] nxt_idx;
   logic [1:0] conv_idx;
   logic conv;
   logic restart;
   logic tick;
   logic abort;
   logic go;
   logic enable;
   logic width4;
   logic list_clk;
   logic master;
   logic trig_level;
   logic ext_edge;
   logic [1:0] list_last;
   logic slow_warn;
   sample_group_pkg::hw_trigger_mode_t trig_mode;
   sample_group_pkg::clock_source_t src;
   logic [1:0] conv_group;
   logic [4:0] nxt_exp;
   logic [6:0] conv_entry;
   logic [6:0] nxt_entry;
   logic [6:0] first_entry;
   logic group_ff;
   logic [1:0] group_id_ff;
   logic [15:0] pin_sel_ff;
   logic [7:0] conv_en_ff;
   logic conv_start_ff;
   logic int_clk_ff;
   logic shr_out_ff;
   logic [4:0] exp_ff;
   logic wr_go;
   logic [7:0] wr_addr;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [31:0] status;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            res[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [6:0] entry(input logic [31:0] lst, input logic [1:0] i);
      return lst[sample_group_pkg::LIST_ENTRY_LSB + sample_group_pkg::LIST_ENTRY_W * i +: 7];
   endfunction

   // configuration fields
   assign enable = ctrl_ff[sample_group_pkg::CTRL_EN_BIT];
   assign trig_mode = sample_group_pkg::hw_trigger_mode_t'(
      ctrl_ff[sample_group_pkg::CTRL_TRIG_LSB +: 2]);
   assign width4 = ctrl_ff[sample_group_pkg::CTRL_WIDTH4_BIT];
   assign list_clk = ctrl_ff[sample_group_pkg::CTRL_LISTCLK_BIT];
   assign src = sample_group_pkg::clock_source_t'(ctrl_ff[sample_group_pkg::CTRL_SRC_LSB +: 2]);
   assign master = ctrl_ff[sample_group_pkg::CTRL_MASTER_BIT];
   assign list_last = list_ff[sample_group_pkg::LIST_LEN_LSB +: 2];

   // pin synchronisers: trigger, external clock, shared clock
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         pin_meta_ff <= 3'h1;
         pin_sync_ff <= 3'h1;
         pin_prev_ff <= 3'h1;
      end
      else
      begin
         pin_meta_ff <= {shared_sample_clock_in, ext_sample_clock_in, ext_trigger_in};
         pin_sync_ff <= pin_meta_ff;
         pin_prev_ff <= pin_sync_ff;
      end
   end

   assign trig_level = pin_sync_ff[0];
   always_comb
   begin
      case (src)
         sample_group_pkg::SRC_EXTERNAL: ext_edge = pin_sync_ff[1] && !pin_prev_ff[1];
         sample_group_pkg::SRC_SHARED: ext_edge = pin_sync_ff[2] && !pin_prev_ff[2];
         default: ext_edge = 1'b0;
      endcase
   end

   // trigger gating
   always_comb
   begin
      case (trig_mode)
         sample_group_pkg::TRIG_ONESHOT: go = trig_level;
         sample_group_pkg::TRIG_GATED: go = trig_level;
         default: go = 1'b1;
      endcase
   end
   assign abort = !enable || (trig_mode == sample_group_pkg::TRIG_GATED && !trig_level);

   // conversion events and list walk
   assign conv_idx = (state_ff == sample_group_pkg::ST_HOLD && list_clk
                      && src == sample_group_pkg::SRC_EXTERNAL) ? 2'h0 : idx_ff;
   always_comb
   begin
      case (state_ff)
         sample_group_pkg::ST_ARM: conv = enable && go && src == sample_group_pkg::SRC_INTERNAL;
         sample_group_pkg::ST_RUN: conv = !abort && tick;
         sample_group_pkg::ST_HOLD: conv = !abort && ext_edge;
         default: conv = 1'b0;
      endcase
   end
   assign nxt_idx = (conv_idx == list_last) ? 2'h0 : conv_idx + 2'h1;
   assign conv_entry = entry(list_ff, conv_idx);
   assign nxt_entry = entry(list_ff, nxt_idx);
   assign first_entry = entry(list_ff, 2'h0);
   assign conv_group = conv_entry[1:0];
   assign nxt_exp = nxt_entry[6:2];

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         sample_group_pkg::ST_IDLE:
         begin
            if (enable)
            begin
               nxt_state = sample_group_pkg::ST_ARM;
            end
         end
         sample_group_pkg::ST_ARM:
         begin
            if (!enable)
            begin
               nxt_state = sample_group_pkg::ST_IDLE;
            end
            else if (go)
            begin
               nxt_state = (src == sample_group_pkg::SRC_INTERNAL) ? sample_group_pkg::ST_RUN
                                                                  : sample_group_pkg::ST_HOLD;
            end
         end
         sample_group_pkg::ST_RUN:
         begin
            if (abort)
            begin
               nxt_state = enable ? sample_group_pkg::ST_ARM : sample_group_pkg::ST_IDLE;
            end
            else if (conv && src != sample_group_pkg::SRC_INTERNAL && nxt_idx == 2'h0)
            begin
               nxt_state = sample_group_pkg::ST_HOLD;
            end
         end
         sample_group_pkg::ST_HOLD:
         begin
            if (abort)
            begin
               nxt_state = enable ? sample_group_pkg::ST_ARM : sample_group_pkg::ST_IDLE;
            end
            else if (conv && list_clk && src == sample_group_pkg::SRC_EXTERNAL
                     && nxt_idx != 2'h0)
            begin
               nxt_state = sample_group_pkg::ST_RUN;
            end
         end
         default: nxt_state = sample_group_pkg::ST_IDLE;
      endcase
   end
   assign restart = nxt_state == sample_group_pkg::ST_RUN && state_ff != sample_group_pkg::ST_RUN;

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         state_ff <= sample_group_pkg::ST_IDLE;
         idx_ff <= 2'h0;
      end
      else
      begin
         state_ff <= nxt_state;
         if (nxt_state == sample_group_pkg::ST_IDLE || nxt_state == sample_group_pkg::ST_ARM)
         begin
            idx_ff <= 2'h0;
         end
         else if (conv)
         begin
            idx_ff <= nxt_idx;
         end
      end
   end

   sample_interval_timer #(
      .INTERVAL_W(INTERVAL_W)
   ) u_timer (
      .clk_sys_in(clk_sys_in),
      .srst_in(srst_in),
      .run_in(state_ff == sample_group_pkg::ST_RUN),
      .restart_in(restart),
      .interval_in(interval_ff[INTERVAL_W-1:0]),
      .tick_out(tick)
   );

   // converter, expansion and clock outputs
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         conv_start_ff <= 1'b0;
         group_ff <= 1'b0;
         group_id_ff <= 2'h0;
         exp_ff <= 5'h00;
         int_clk_ff <= 1'b0;
         shr_out_ff <= 1'b0;
      end
      else
      begin
         conv_start_ff <= conv;
         int_clk_ff <= conv && src == sample_group_pkg::SRC_INTERNAL;
         shr_out_ff <= conv && master && src == sample_group_pkg::SRC_INTERNAL;
         if (conv)
         begin
            group_ff <= conv_group[0];
            group_id_ff <= width4 ? conv_group : {1'b0, conv_group[0]};
            exp_ff <= nxt_exp;
         end
         else if (state_ff == sample_group_pkg::ST_IDLE || state_ff == sample_group_pkg::ST_ARM)
         begin
            exp_ff <= first_entry[6:2];
         end
      end
   end

   for (genvar p = 0; p < 16; p++)
   begin : g_pin
      always_ff @(posedge clk_sys_in)
      begin
         if (srst_in)
         begin
            pin_sel_ff[p] <= 1'b0;
         end
         else if (conv)
         begin
            pin_sel_ff[p] <= (p % 2 == conv_group[0])
                             && (!width4 || (p / 8 == conv_group[1]));
         end
      end
      if (p < 8)
      begin : g_conv
         always_ff @(posedge clk_sys_in)
         begin
            if (srst_in)
            begin
               conv_en_ff[p] <= 1'b0;
            end
            else if (conv)
            begin
               conv_en_ff[p] <= !width4 || (p / 4 == conv_group[1]);
            end
         end
      end
   end

   assign conv_start_out = conv_start_ff;
   assign pin_select_out = pin_sel_ff;
   assign conv_enable_out = conv_en_ff;
   assign mux_odd_out = group_ff;
   assign group_out = group_id_ff;
   assign expansion_select_out = exp_ff;
   assign internal_sample_clock_out = int_clk_ff;
   assign shared_sample_clock_out = shr_out_ff;
   assign range_10v_out = ctrl_ff[sample_group_pkg::CTRL_RANGE10_BIT];
   assign slow_warn = range_10v_out && list_last != 2'h0
                      && interval_ff < 32'(sample_group_pkg::RANGE10_MIN_CYC);

   // register slave
   assign s_axi_awready_out = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_ff;
   assign s_axi_wready_out = s_axi_awready_out;
   assign wr_go = s_axi_awready_out;
   assign wr_addr = {s_axi_awaddr_in[7:2], 2'b00};
   assign s_axi_arready_out = !rvalid_ff;
   assign status = {23'h0, state_ff != sample_group_pkg::ST_IDLE
                    && state_ff != sample_group_pkg::ST_ARM, slow_warn, trig_level, idx_ff,
                    state_ff};

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         ctrl_ff <= sample_group_pkg::CTRL_RESET;
         interval_ff <= sample_group_pkg::INTERVAL_RESET;
         list_ff <= sample_group_pkg::LIST_RESET;
      end
      else if (wr_go)
      begin
         case (wr_addr)
            sample_group_pkg::ADDR_CTRL:
               ctrl_ff <= merge(ctrl_ff, s_axi_wdata_in, s_axi_wstrb_in) & 32'h0000_01FF;
            sample_group_pkg::ADDR_INTERVAL:
               interval_ff <= merge(interval_ff, s_axi_wdata_in, s_axi_wstrb_in);
            sample_group_pkg::ADDR_LIST:
               list_ff <= merge(list_ff, s_axi_wdata_in, s_axi_wstrb_in) & 32'h3FFF_FFFF;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff <= sample_group_pkg::RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff <= (wr_addr <= sample_group_pkg::ADDR_STATUS) ? sample_group_pkg::RESP_OKAY
                                                                : sample_group_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready_in)
      begin
         bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= sample_group_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid_in && !rvalid_ff)
      begin
         rvalid_ff <= 1'b1;
         rresp_ff <= sample_group_pkg::RESP_OKAY;
         case ({s_axi_araddr_in[7:2], 2'b00})
            sample_group_pkg::ADDR_CTRL: rdata_ff <= ctrl_ff;
            sample_group_pkg::ADDR_INTERVAL: rdata_ff <= interval_ff;
            sample_group_pkg::ADDR_LIST: rdata_ff <= list_ff;
            sample_group_pkg::ADDR_STATUS: rdata_ff <= status;
            default:
            begin
               rdata_ff <= 32'h0000_0000;
               rresp_ff <= sample_group_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready_in)
      begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_bvalid_out = bvalid_ff;
   assign s_axi_bresp_out = bresp_ff;
   assign s_axi_rvalid_out = rvalid_ff;
   assign s_axi_rdata_out = rdata_ff;
   assign s_axi_rresp_out = rresp_ff;

   // checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (srst_in);

   AST_TRIG_IGNORED: assert property (
      state_ff == sample_group_pkg::ST_ARM && enable && trig_mode == sample_group_pkg::TRIG_OFF
      |=> state_ff inside {sample_group_pkg::ST_RUN, sample_group_pkg::ST_HOLD})
      else $error("trigger mode off did not start sampling");
   AST_GATE_STOP: assert property (
      state_ff == sample_group_pkg::ST_RUN && enable && trig_mode == sample_group_pkg::TRIG_GATED
      && !trig_level |=> state_ff == sample_group_pkg::ST_ARM && !conv_start_ff)
      else $error("gate low did not stop sampling");
   AST_WIDTH8: assert property (
      conv_start_ff && $past(!width4) |-> $countones(pin_sel_ff) == 8
      && (pin_sel_ff == 16'h5555 || pin_sel_ff == 16'hAAAA))
      else $error("eight-wide group membership wrong");
   AST_WIDTH4: assert property (
      conv_start_ff && $past(width4) |-> pin_sel_ff inside {16'h0055, 16'h00AA, 16'h5500,
      16'hAA00} && $countones(conv_en_ff) == 4)
      else $error("four-wide group membership wrong");
   AST_EXP_EARLY: assert property (
      conv && $stable(list_ff) && state_ff == sample_group_pkg::ST_RUN
      |-> exp_ff == conv_entry[6:2])
      else $error("expansion select not set ahead of sample");
   AST_WRAP: assert property (
      conv && conv_idx == list_last && !restart |=> idx_ff == 2'h0)
      else $error("list did not wrap to first group");
   AST_INT_CLOCK: assert property (
      conv && src == sample_group_pkg::SRC_INTERNAL |=> internal_sample_clock_out
      && conv_start_out ##1 !internal_sample_clock_out || conv_start_out)
      else $error("internal clock copy missing");
   AST_MASTER_OUT: assert property (
      shared_sample_clock_out |-> $past(master) && internal_sample_clock_out)
      else $error("shared clock driven without master role");
   AST_LIST_EDGE: assert property (
      state_ff == sample_group_pkg::ST_HOLD && list_clk && !abort
      && src == sample_group_pkg::SRC_EXTERNAL && ext_edge
      |=> conv_start_ff && group_ff == $past(first_entry[0]))
      else $error("list clock edge did not start list");
   AST_OPEN_TRIG: assert property (
      $fell(srst_in) |-> trig_level)
      else $error("trigger not seen asserted after reset");

   COV_WRAP: cover property (conv && conv_idx == list_last && list_last != 2'h0);
   COV_GATE: cover property (state_ff == sample_group_pkg::ST_RUN
      ##1 state_ff == sample_group_pkg::ST_ARM);
   COV_LIST: cover property (state_ff == sample_group_pkg::ST_HOLD
      ##1 state_ff == sample_group_pkg::ST_RUN);
endmodule

// ---- sample_interval_timer.sv ----
// sample interval timer: one tick every interval cycles while running
`timescale 1ns/100ps
module sample_interval_timer #(
   parameter int INTERVAL_W = 32
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic srst_in,
   // control
   input wire logic run_in,
   input wire logic restart_in,
   input wire logic [INTERVAL_W-1:0] interval_in,
   // tick
   output logic tick_out
);
   logic [INTERVAL_W-1:0] count_ff;
   logic [INTERVAL_W-1:0] reload;

   // an interval of zero is served as one cycle
   assign reload = (interval_in == '0) ? '0 : interval_in - 1'b1;
   assign tick_out = run_in && !restart_in && (count_ff == '0);

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         count_ff <= '0;
      end
      else if (restart_in || tick_out)
      begin
         count_ff <= reload;
      end
      else if (run_in)
      begin
         count_ff <= count_ff - 1'b1;
      end
   end
endmodule

// ---- tb.sv ----
// self-checking bench for the sample group sequencer
`timescale 1ns/100ps
module tb;
   logic clk_sys_in, srst_in, ext_trigger_in, ext_sample_clock_in, shared_sample_clock_in;
   logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   logic s_axi_rvalid_out, internal_sample_clock_out, shared_sample_clock_out;
   logic conv_start_out, mux_odd_out, range_10v_out, drive_en, trig_level, edge_req;
   logic [7:0] s_axi_awaddr_in, s_axi_araddr_in, conv_enable_out;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
   logic [3:0] s_axi_wstrb_in;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, group_out;
   logic [4:0] expansion_select_out;
   logic [15:0] pin_select_out;
   int err_count, samples_checked, cycles;

   sample_group_sequencer #(.INTERVAL_W(16)) dut (
      .clk_sys_in, .srst_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_awaddr_in,
      .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_bvalid_out,
      .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out,
      .s_axi_araddr_in, .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out,
      .ext_trigger_in, .ext_sample_clock_in, .shared_sample_clock_in, .internal_sample_clock_out,
      .shared_sample_clock_out, .expansion_select_out, .conv_start_out, .pin_select_out,
      .conv_enable_out, .mux_odd_out, .group_out, .range_10v_out);
   far_side_model model (.clk_sys_in, .drive_en_in(drive_en), .trig_level_in(trig_level),
      .edge_req_in(edge_req), .ext_trigger_out(ext_trigger_in),
      .ext_sample_clock_out(ext_sample_clock_in), .shared_sample_clock_out(shared_sample_clock_in));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      {aw, w} = 2'h0;
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
      {s_axi_awaddr_in, s_axi_wdata_in} <= {a, d};
      while (!(aw && w))
      begin
         @(posedge clk_sys_in);
         {aw, w} = {aw | s_axi_awready_out, w | s_axi_wready_out};
         if (aw) s_axi_awvalid_in <= 1'b0;
         if (w) s_axi_wvalid_in <= 1'b0;
      end
      while (s_axi_bvalid_out !== 1'b1) @(posedge clk_sys_in);
      chk(s_axi_bresp_out, (a > sample_group_pkg::ADDR_STATUS) ? sample_group_pkg::RESP_SLVERR
                                                               : sample_group_pkg::RESP_OKAY);
      s_axi_bready_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      {s_axi_arvalid_in, s_axi_rready_in, s_axi_araddr_in} <= {2'h3, a};
      do @(posedge clk_sys_in); while (s_axi_arready_out !== 1'b1);
      s_axi_arvalid_in <= 1'b0;
      do @(posedge clk_sys_in); while (s_axi_rvalid_out !== 1'b1);
      {d, r} = {s_axi_rdata_out, s_axi_rresp_out};
      s_axi_rready_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic ctl(input logic [31:0] d);
      wr(sample_group_pkg::ADDR_CTRL, d);
   endtask
   function automatic logic [31:0] lst(input logic [1:0] n, input logic [27:0] e);
      return {2'h0, e, n};
   endfunction
   // counts edges up to the next conversion, lim plus one when none comes
   task automatic wait_conv(input int lim, output int n);
      n = 0;
      do
      begin
         @(posedge clk_sys_in);
         n++;
      end
      while (conv_start_out !== 1'b1 && n <= lim);
   endtask
   task automatic grp(input int gap, input logic [15:0] p, input logic [1:0] g, input logic [4:0] e);
      int n;
      wait_conv(20, n);
      if (gap > 0) chk(n, gap);
      chk(n <= 20, 1);
      chk(pin_select_out, p);
      chk(group_out, g);
      chk(expansion_select_out, e);
   endtask

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      rd(sample_group_pkg::ADDR_CTRL, d, r);
      chk(d, sample_group_pkg::CTRL_RESET);
      rd(sample_group_pkg::ADDR_LIST, d, r);
      chk(d, sample_group_pkg::LIST_RESET);
      rd(8'h10, d, r);
      chk(r, sample_group_pkg::RESP_SLVERR);
      chk(d, 32'h0000_0000);
      wr(8'h10, 32'h0000_0001);
      ctl(32'h0000_0010);
      chk(range_10v_out, 1'b1);
      rd(sample_group_pkg::ADDR_STATUS, d, r);
      chk(d, 32'h0000_00C1);
      ctl(32'h0000_0000);
      chk(range_10v_out, 1'b0);
      $display("test regs done");
   endtask
   task automatic t_run8;
      wr(sample_group_pkg::ADDR_INTERVAL, 32'h0000_0004);
      wr(sample_group_pkg::ADDR_LIST, lst(2'h1, {14'h0, 7'h15, 7'h0C}));
      ctl(32'h0000_0101);
      grp(0, 16'h5555, 2'h0, 5'h05);
      chk({shared_sample_clock_out, internal_sample_clock_out, conv_enable_out}, 10'h3FF);
      grp(4, 16'hAAAA, 2'h1, 5'h03);
      chk(mux_odd_out, 1'b1);
      grp(4, 16'h5555, 2'h0, 5'h05);
      ctl(32'h0000_0000);
      $display("test eight-wide done");
   endtask
   task automatic t_run4;
      logic [15:0] p [4] = '{16'h0055, 16'h00AA, 16'h5500, 16'hAA00};
      wr(sample_group_pkg::ADDR_LIST, lst(2'h3, {7'h0F, 7'h0A, 7'h05, 7'h00}));
      ctl(32'h0000_0009);
      for (int i = 0; i < 5; i++)
         grp(i ? 4 : 0, p[i % 4], 2'(i % 4), 5'((i + 1) % 4));
      ctl(32'h0000_0000);
      $display("test four-wide done");
   endtask
   task automatic t_trig;
      int n;
      {drive_en, trig_level} <= 2'h2;
      repeat (4) @(posedge clk_sys_in);
      ctl(32'h0000_0005);
      wait_conv(30, n);
      chk(n, 31);
      trig_level <= 1'b1;
      wait_conv(20, n);
      chk(n <= 20, 1);
      trig_level <= 1'b0;
      repeat (8) @(posedge clk_sys_in);
      wait_conv(30, n);
      chk(n, 31);
      ctl(32'h0000_0001);
      wait_conv(20, n);
      chk(n <= 20, 1);
      ctl(32'h0000_0000);
      drive_en <= 1'b0;
      ctl(32'h0000_0003);
      wait_conv(20, n);
      chk(n <= 20, 1);
      drive_en <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      wait_conv(20, n);
      chk(n <= 20, 1);
      ctl(32'h0000_0000);
      $display("test trigger done");
   endtask
   task automatic t_list;
      int n;
      wr(sample_group_pkg::ADDR_LIST, lst(2'h1, {14'h0, 7'h15, 7'h0C}));
      ctl(32'h0000_0061);
      repeat (2)
      begin
         edge_req <= 1'b1;
         @(posedge clk_sys_in);
         edge_req <= 1'b0;
         grp(0, 16'h5555, 2'h0, 5'h05);
         grp(4, 16'hAAAA, 2'h1, 5'h03);
         wait_conv(30, n);
         chk(n, 31);
      end
      ctl(32'h0000_0000);
      ctl(32'h0000_0081);
      for (int i = 0; i < 2; i++)
      begin
         edge_req <= 1'b1;
         @(posedge clk_sys_in);
         edge_req <= 1'b0;
         grp(0, i ? 16'hAAAA : 16'h5555, 2'(i), i ? 5'h03 : 5'h05);
         repeat (4) @(posedge clk_sys_in);
      end
      ctl(32'h0000_0000);
      $display("test list clocking done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         report_and_stop();
      end
   end
   initial
   begin
      {srst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 4'h8;
      {s_axi_arvalid_in, s_axi_rready_in, drive_en, trig_level, edge_req} = 5'h0;
      {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, s_axi_wstrb_in} = 52'hF;
      repeat (4) @(posedge clk_sys_in);
      srst_in <= 1'b0;
      @(posedge clk_sys_in);
      t_regs();
      t_run8();
      t_run4();
      t_trig();
      t_list();
      report_and_stop();
   end
endmodule
